/* design/spi_slave_control_status.sv */
// Byte-wide serial slave with control/status, buffers, select source and interrupt
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module spi_slave_control_status (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [spi_slave_pkg::ADDR_W-1:0] addr,
   input wire logic [spi_slave_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [spi_slave_pkg::DATA_W-1:0] rd_data,
   input wire logic sclk,
   input wire logic select_n_pin,
   input wire logic mosi,
   output logic miso,
   output logic irq
);
   import spi_slave_pkg::*;

   state_type state;
   state_type next_state;
   logic select_n;
   logic active_select;
   logic sclk_edge;
   logic leading;
   logic capture;
   logic change;
   logic done_event;
   logic load_event;
   logic [DATA_W-1:0] rx_next;

   // First bit of a byte for the chosen order
   function automatic logic first_bit(input logic [DATA_W-1:0] value, input logic low_first);
      first_bit = low_first ? value[0] : value[DATA_W-1];
   endfunction

   // Select source, edge classes and transfer events
   always_comb begin
      select_n = state.software_select_source ? state.soft_select_n : state.pin_select_n;
      active_select = state.ctrl[ENABLE_BIT] && !select_n;
      sclk_edge = (state.sync.sclk[1] == state.sync.sclk[2]) && (state.sync.sclk[2] != state.sclk_level);
      leading = state.sync.sclk[2] != state.ctrl[POLARITY_BIT]; // Away from idle level
      capture = sclk_edge && (leading ^ state.ctrl[PHASE_BIT]);
      change = sclk_edge && !(leading ^ state.ctrl[PHASE_BIT]);
      load_event = (state.link == link_idle) && active_select && state.select_prev_n;
      done_event = (state.link == link_active) && active_select && capture && (state.bit_count == 3'h7);
      if (state.ctrl[ORDER_BIT]) begin
         rx_next = {state.mosi_level, state.rx_shift[DATA_W-1:1]};
      end else begin
         rx_next = {state.rx_shift[DATA_W-2:0], state.mosi_level};
      end
   end

   // Whole next state; synchronous reset handled here
   always_comb begin
      next_state = state;
      next_state.rd_data = '0;
      // Three-stage sampling; a level only counts once stages two and three agree
      next_state.sync.sclk = {state.sync.sclk[1:0], sclk};
      next_state.sync.select_n = {state.sync.select_n[1:0], select_n_pin};
      next_state.sync.mosi = {state.sync.mosi[1:0], mosi};
      if (state.sync.sclk[1] == state.sync.sclk[2]) begin
         next_state.sclk_level = state.sync.sclk[2];
      end
      if (state.sync.select_n[1] == state.sync.select_n[2]) begin
         next_state.pin_select_n = state.sync.select_n[2];
      end
      if (state.sync.mosi[1] == state.sync.mosi[2]) begin
         next_state.mosi_level = state.sync.mosi[2];
      end
      next_state.select_prev_n = !active_select;

      // Register reads; flag clears come before hardware sets so sets win
      if (rd_en) begin
         unique case (addr)
            CTRL_STATUS_ADDR: begin
               next_state.rd_data = state.ctrl;
               next_state.ctrl[DONE_BIT] = 1'b0;
               next_state.ctrl[OVERRUN_BIT] = 1'b0;
               next_state.ctrl[RX_FULL_BIT] = 1'b0;
            end
            TX_DATA_ADDR: next_state.rd_data = state.tx_buf;
            RX_DATA_ADDR: begin
               next_state.rd_data = state.rx_buf;
               next_state.ctrl[RX_FULL_BIT] = 1'b0;
            end
            SELECT_ADDR: next_state.rd_data = {6'h00, state.soft_select_n, state.software_select_source};
            IRQ_STATUS_ADDR: next_state.rd_data = {5'h00, state.irq_status};
            IRQ_ENABLE_ADDR: next_state.rd_data = {5'h00, state.irq_enable};
            default: next_state.rd_data = '0;
         endcase
      end

      // Register writes; flag bits of control/status are read-only
      if (wr_en) begin
         unique case (addr)
            CTRL_STATUS_ADDR: begin
               next_state.ctrl = (state.ctrl & ~CTRL_WRITE_MASK) | (wr_data & CTRL_WRITE_MASK);
            end
            TX_DATA_ADDR: next_state.tx_buf = wr_data;
            SELECT_ADDR: begin
               next_state.software_select_source = wr_data[SOURCE_BIT];
               next_state.soft_select_n = wr_data[LEVEL_BIT];
            end
            IRQ_CLEAR_ADDR: next_state.irq_status = state.irq_status & ~wr_data[IRQ_W-1:0];
            IRQ_ENABLE_ADDR: next_state.irq_enable = wr_data[IRQ_W-1:0];
            default: ;
         endcase
      end

      // Link sequencing
      unique case (state.link)
         link_idle: begin
            if (load_event) begin
               next_state.link = link_active;
               next_state.tx_shift = state.tx_buf;
               next_state.miso = first_bit(state.tx_buf, state.ctrl[ORDER_BIT]);
               next_state.bit_count = 3'h0;
               next_state.ctrl[TX_EMPTY_BIT] = 1'b1;
               next_state.irq_status[IRQ_TX_EMPTY_BIT] = 1'b1;
            end
         end
         link_active: begin
            if (!active_select) begin
               // Deselect or disable abandons a partial byte
               next_state.link = link_idle;
            end else if (capture) begin
               next_state.rx_shift = rx_next;
               next_state.bit_count = state.bit_count + 3'h1;
               if (done_event) begin
                  if (next_state.ctrl[RX_FULL_BIT]) begin
                     next_state.ctrl[OVERRUN_BIT] = 1'b1;
                     next_state.irq_status[IRQ_OVERRUN_BIT] = 1'b1;
                  end
                  next_state.rx_buf = rx_next;
                  next_state.tx_shift = state.tx_buf;
                  next_state.miso = first_bit(state.tx_buf, state.ctrl[ORDER_BIT]);
                  next_state.ctrl[RX_FULL_BIT] = 1'b1;
                  next_state.ctrl[DONE_BIT] = 1'b1;
                  next_state.ctrl[TX_EMPTY_BIT] = 1'b1;
                  next_state.irq_status[IRQ_DONE_BIT] = 1'b1;
                  next_state.irq_status[IRQ_TX_EMPTY_BIT] = 1'b1;
               end
            end else if (change && state.bit_count != 3'h0) begin
               // No shift before the first capture, so phase 1 keeps its first bit
               if (state.ctrl[ORDER_BIT]) begin
                  next_state.tx_shift = state.tx_shift >> 1;
                  next_state.miso = state.tx_shift[1];
               end else begin
                  next_state.tx_shift = state.tx_shift << 1;
                  next_state.miso = state.tx_shift[DATA_W-2];
               end
            end
         end
      endcase

      // A fresh byte from software overrides a same-cycle load
      if (wr_en && addr == TX_DATA_ADDR) begin
         next_state.ctrl[TX_EMPTY_BIT] = 1'b0;
      end
      next_state.irq = |(next_state.irq_status & next_state.irq_enable);

      if (!reset_n) begin
         next_state = '0;
         next_state.sync.sclk = '0;
         next_state.sync.select_n = '1; // Idle deselected, so no false fall after reset
         next_state.sclk_level = 1'b0;
         next_state.pin_select_n = 1'b1;
         next_state.select_prev_n = 1'b1;
         next_state.soft_select_n = 1'b1;
         next_state.ctrl = CTRL_RESET;
         next_state.link = link_idle;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      state <= next_state;
   end

   assign rd_data = state.rd_data;
   assign miso = state.miso;
   assign irq = state.irq;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence byte_done_s;
      done_event;
   endsequence
   sequence ctrl_write_s;
      wr_en && addr == CTRL_STATUS_ADDR;
   endsequence

   mode_bits_a: assert property (ctrl_write_s |=> state.ctrl[2:1] == $past(wr_data[2:1]))
      else $error("mode bits not taken");
   order_shift_a: assert property ((state.link == link_active) && active_select && change
      && state.bit_count != 3'h0 && state.ctrl[ORDER_BIT] |=> miso == $past(state.tx_shift[1]))
      else $error("low-first shift wrong");
   start_link_a: assert property (load_event |=> state.link == link_active
      && (state.ctrl[TX_EMPTY_BIT] || $past(wr_en && addr == TX_DATA_ADDR)))
      else $error("select fall did not start link");
   stop_link_a: assert property (!state.ctrl[ENABLE_BIT] |=> state.link == link_idle)
      else $error("disabled slave still active");
   irq_raise_a: assert property (byte_done_s ##0 state.irq_enable[IRQ_DONE_BIT]
      && !(wr_en && addr == IRQ_ENABLE_ADDR) |=> irq)
      else $error("done interrupt missing");
   irq_quiet_a: assert property (state.irq_enable == '0 |-> !irq)
      else $error("masked interrupt raised");
   tx_load_a: assert property (wr_en && addr == TX_DATA_ADDR |=> state.tx_buf == $past(wr_data)
      && !state.ctrl[TX_EMPTY_BIT])
      else $error("transmit buffer write lost");
   rx_read_a: assert property (rd_en && addr == RX_DATA_ADDR && !done_event
      |=> rd_data == $past(state.rx_buf) ##1 (rd_data == '0 || $past(rd_en)))
      else $error("receive read data wrong");
   status_read_a: assert property (rd_en && addr == CTRL_STATUS_ADDR && !done_event
      |=> rd_data == $past(state.ctrl) && !state.ctrl[DONE_BIT] && !state.ctrl[OVERRUN_BIT])
      else $error("status read or clear wrong");
   soft_select_a: assert property (wr_en && addr == SELECT_ADDR && wr_data[SOURCE_BIT]
      |=> select_n == $past(wr_data[LEVEL_BIT]))
      else $error("software select not applied");
   pin_select_a: assert property (!state.software_select_source |-> select_n == state.pin_select_n)
      else $error("pin select overridden");
   capture_count_a: assert property ((state.link == link_active) && active_select && capture
      |=> state.bit_count == $past(state.bit_count) + 3'h1)
      else $error("capture edge not counted");
   load_shift_a: assert property (load_event |=> state.tx_shift == $past(state.tx_buf))
      else $error("shift not loaded on select");
   complete_a: assert property (byte_done_s |=> state.ctrl[RX_FULL_BIT] && state.ctrl[DONE_BIT]
      && state.rx_buf == $past(rx_next))
      else $error("byte completion wrong");
   overrun_a: assert property (byte_done_s ##0 state.ctrl[RX_FULL_BIT] && !rd_en |=> state.ctrl[OVERRUN_BIT])
      else $error("overrun not flagged");

   // Bus side: read data stands one cycle only, refused reads stay zero
   read_idle_a: assert property (!rd_en |=> rd_data == '0)
      else $error("read data outside its cycle");
   refused_read_a: assert property (rd_en && addr == IRQ_CLEAR_ADDR |=> rd_data == '0)
      else $error("clear register readable");
   rx_full_clear_a: assert property (rd_en && addr == RX_DATA_ADDR && !done_event
      |=> !state.ctrl[RX_FULL_BIT])
      else $error("receive read left full flag");
   // Flags are hardware-owned; a control write must not forge or wipe them
   flag_write_a: assert property (ctrl_write_s ##0 !done_event && !load_event
      |=> state.ctrl[OVERRUN_BIT:RX_FULL_BIT] == $past(state.ctrl[OVERRUN_BIT:RX_FULL_BIT]))
      else $error("control write touched flags");
   soft_ignore_a: assert property (wr_en && addr == SELECT_ADDR && !wr_data[SOURCE_BIT]
      |=> select_n == state.pin_select_n)
      else $error("software level used with pin source");

   // Link side: a pin level only moves once two sampler stages agree
   sync_agree_a: assert property (state.sync.select_n[1] != state.sync.select_n[2]
      |=> state.pin_select_n == $past(state.pin_select_n))
      else $error("select taken before sampler settled");
   first_bit_a: assert property (load_event |=> miso == ($past(state.ctrl[ORDER_BIT])
      ? $past(state.tx_buf[0]) : $past(state.tx_buf[DATA_W-1])))
      else $error("first bit not presented");
   tx_empty_set_a: assert property (load_event && !(wr_en && addr == TX_DATA_ADDR)
      |=> state.ctrl[TX_EMPTY_BIT] && state.irq_status[IRQ_TX_EMPTY_BIT])
      else $error("transmit empty not set on load");
   idle_hold_a: assert property (state.link == link_idle && !active_select
      |=> $stable(state.tx_shift) && $stable(state.rx_shift))
      else $error("idle slave shifted");
   capture_bit_a: assert property ((state.link == link_active) && active_select && capture
      && !state.ctrl[ORDER_BIT] |=> state.rx_shift[0] == $past(state.mosi_level))
      else $error("captured bit wrong");

   // Shift steps only after the first capture of a byte
   sequence shift_step_s;
      (state.link == link_active) && active_select && change && state.bit_count != 3'h0;
   endsequence
   high_first_shift_a: assert property (shift_step_s ##0 !state.ctrl[ORDER_BIT]
      |=> miso == $past(state.tx_shift[DATA_W-2]))
      else $error("high-first shift wrong");
   shift_reload_a: assert property (byte_done_s |=> state.tx_shift == $past(state.tx_buf))
      else $error("shifter not reloaded");
   done_irq_a: assert property (byte_done_s |=> state.irq_status[IRQ_DONE_BIT])
      else $error("done event not latched");
   overrun_quiet_a: assert property (byte_done_s ##0 !state.ctrl[RX_FULL_BIT] && !state.ctrl[OVERRUN_BIT]
      |=> !state.ctrl[OVERRUN_BIT])
      else $error("overrun without unread byte");
endmodule

`default_nettype wire

/* common/spi_slave_pkg.sv */
// Shared constants and types of the byte-wide serial slave
package spi_slave_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   localparam int IRQ_W = 3;
   localparam int SYNC_STAGES = 3;

   // Register word addresses
   localparam logic [ADDR_W-1:0] CTRL_STATUS_ADDR = 3'h0;
   localparam logic [ADDR_W-1:0] TX_DATA_ADDR = 3'h1;
   localparam logic [ADDR_W-1:0] RX_DATA_ADDR = 3'h2;
   localparam logic [ADDR_W-1:0] SELECT_ADDR = 3'h3;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 3'h4;
   localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = 3'h5;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 3'h6;

   // Control/status field positions
   localparam int ENABLE_BIT = 0;
   localparam int POLARITY_BIT = 1;
   localparam int PHASE_BIT = 2;
   localparam int RX_FULL_BIT = 3;
   localparam int TX_EMPTY_BIT = 4;
   localparam int DONE_BIT = 5;
   localparam int OVERRUN_BIT = 6;
   localparam int ORDER_BIT = 7;

   // Configuration codes and status masks as software sees them
   localparam logic [DATA_W-1:0] mode_zero_code = 8'h00;
   localparam logic [DATA_W-1:0] mode_one_code = 8'h02;
   localparam logic [DATA_W-1:0] mode_two_code = 8'h04;
   localparam logic [DATA_W-1:0] mode_three_code = 8'h06;
   localparam logic [DATA_W-1:0] low_bit_first_setting = 8'h80;
   localparam logic [DATA_W-1:0] high_bit_first_setting = 8'h00;
   localparam logic [DATA_W-1:0] transfer_done_flag = 8'h20;
   localparam logic [DATA_W-1:0] receive_overrun_flag = 8'h40;
   localparam logic [DATA_W-1:0] transmit_empty_flag = 8'h10;
   localparam logic [DATA_W-1:0] receive_full_flag = 8'h08;
   localparam logic [DATA_W-1:0] CTRL_WRITE_MASK = 8'h87;
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h10;

   // Select register fields
   localparam int SOURCE_BIT = 0;
   localparam int LEVEL_BIT = 1;

   // Interrupt status/enable/clear fields
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_OVERRUN_BIT = 1;
   localparam int IRQ_TX_EMPTY_BIT = 2;

   typedef enum logic {link_idle = 1'b0, link_active = 1'b1} link_state_type;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] sclk;
      logic [SYNC_STAGES-1:0] select_n;
      logic [SYNC_STAGES-1:0] mosi;
   } pin_sync_type;

   typedef struct packed {
      link_state_type link;
      pin_sync_type sync;
      logic sclk_level;
      logic pin_select_n;
      logic mosi_level;
      logic select_prev_n;
      logic [DATA_W-1:0] ctrl;
      logic [DATA_W-1:0] tx_buf;
      logic [DATA_W-1:0] rx_buf;
      logic [DATA_W-1:0] tx_shift;
      logic [DATA_W-1:0] rx_shift;
      logic [2:0] bit_count;
      logic software_select_source;
      logic soft_select_n;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_enable;
      logic miso;
      logic irq;
      logic [DATA_W-1:0] rd_data;
   } state_type;
endpackage

/* testbench/spi_master_model.sv */
// Behavioural serial master that clocks byte frames into the slave
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
   input wire logic clk,
   output logic sclk,
   output logic select_n_pin,
   output logic mosi,
   input wire logic miso
);
   localparam time HALF = 160;
   // Idle: deselected, clock still between frames
   initial begin
      sclk = 1'b0;
      select_n_pin = 1'b1;
      mosi = 1'b1;
   end
   // One frame; miso taken a quarter period after the capture edge:
   // the slave answers 3-4 clk after an edge, so the bit has settled
   // and the end-of-byte reload has not yet replaced it
   task automatic xfer(input logic [7:0] cfg, input logic [7:0] tx, input logic use_pin, output logic [7:0] rx);
      int k;
      @(posedge clk);
      #7 sclk = cfg[1];
      #(HALF) select_n_pin = !use_pin;
      #(HALF);
      for (int i = 0; i < 8; i++) begin
         k = cfg[7] ? i : 7 - i;
         if (cfg[2]) begin
            // Change on leading, capture on trailing
            sclk = !cfg[1];
            mosi = tx[k];
            #(HALF) sclk = cfg[1];
         end else begin
            // Capture on leading, change on trailing
            mosi = tx[k];
            #(HALF) sclk = !cfg[1];
         end
         #(HALF/2) rx[k] = miso;
         #(HALF/2) sclk = cfg[1];
      end
      #(2*HALF) select_n_pin = 1'b1;
      mosi = !mosi; // Released line shows no stale bit
   endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench of the serial slave: bus, frames, interrupt, select
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
   $display("MISMATCH at %0t got %h expected %h", $time, a, b); end end
module tb;
   import spi_slave_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wr_data = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [DATA_W-1:0] rd_data;
   logic sclk, select_n_pin, mosi, miso, irq;
   logic [7:0] got;
   logic [7:0] codes [4] = '{mode_zero_code, mode_one_code, mode_two_code, mode_three_code};
   int miscompares = 0;
   int check_count = 0;
   // 25 MHz system clock
   always #20 clk = ~clk;
   spi_slave_control_status i_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sclk(sclk), .select_n_pin(select_n_pin),
      .mosi(mosi), .miso(miso), .irq(irq));
   spi_master_model i_master (.clk(clk), .sclk(sclk), .select_n_pin(select_n_pin), .mosi(mosi), .miso(miso));
   // Bus write, one strobe cycle
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Bus read; data judged in the one cycle it stands
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 `CHK(rd_data, exp)
   endtask
   // Interrupt level after its registered update
   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge clk);
      #1 `CHK(irq, exp)
   endtask
   // Every mode in both bit orders, a full frame each
   task automatic modes_and_orders();
      logic [7:0] cfg, m, s;
      for (int i = 0; i < 8; i++) begin
         cfg = codes[i % 4] | (i > 3 ? low_bit_first_setting : high_bit_first_setting) | 8'h01;
         m = 8'h1E + 8'(i);
         s = 8'hC5 - 8'(i);
         wr(CTRL_STATUS_ADDR, cfg);
         wr(TX_DATA_ADDR, s);
         rd_chk(CTRL_STATUS_ADDR, cfg);
         i_master.xfer(cfg, m, 1'b1, got);
         `CHK(got, s)
         rd_chk(CTRL_STATUS_ADDR, cfg | transfer_done_flag | receive_full_flag | transmit_empty_flag);
         rd_chk(CTRL_STATUS_ADDR, cfg | transmit_empty_flag);
         rd_chk(RX_DATA_ADDR, m);
      end
   endtask
   // Second byte lands before the first is read
   task automatic overrun_case();
      wr(CTRL_STATUS_ADDR, mode_zero_code | 8'h01);
      i_master.xfer(mode_zero_code, 8'h5A, 1'b1, got);
      i_master.xfer(mode_zero_code, 8'h96, 1'b1, got);
      rd_chk(CTRL_STATUS_ADDR, receive_overrun_flag | transfer_done_flag | transmit_empty_flag
         | receive_full_flag | 8'h01);
      rd_chk(RX_DATA_ADDR, 8'h96);
   endtask
   // Done interrupt masked, unmasked, cleared; refused reads
   task automatic irq_case();
      wr(IRQ_CLEAR_ADDR, 8'h07);
      i_master.xfer(mode_zero_code, 8'hE1, 1'b1, got);
      rd_chk(IRQ_STATUS_ADDR, 8'h05);
      irq_chk(1'b0);
      wr(IRQ_ENABLE_ADDR, 8'h01);
      irq_chk(1'b1);
      rd_chk(IRQ_ENABLE_ADDR, 8'h01);
      wr(IRQ_CLEAR_ADDR, 8'h01);
      irq_chk(1'b0);
      rd_chk(IRQ_CLEAR_ADDR, 8'h00);
      rd_chk(3'h7, 8'h00);
      rd_chk(CTRL_STATUS_ADDR, 8'h39);
      rd_chk(RX_DATA_ADDR, 8'hE1);
   endtask
   // Enable cleared: a whole frame leaves no trace
   task automatic disable_case();
      wr(CTRL_STATUS_ADDR, mode_zero_code);
      i_master.xfer(mode_zero_code, 8'hA3, 1'b1, got);
      rd_chk(CTRL_STATUS_ADDR, transmit_empty_flag);
      irq_chk(1'b0);
   endtask
   // Software-driven select; the pin is ignored meanwhile
   task automatic soft_select_case();
      wr(CTRL_STATUS_ADDR, mode_zero_code | 8'h01);
      wr(TX_DATA_ADDR, 8'h69);
      rd_chk(TX_DATA_ADDR, 8'h69);
      wr(SELECT_ADDR, 8'h03);
      i_master.xfer(mode_zero_code, 8'h33, 1'b1, got);
      rd_chk(CTRL_STATUS_ADDR, 8'h01);
      wr(SELECT_ADDR, 8'h01);
      rd_chk(SELECT_ADDR, 8'h01);
      repeat (8) @(posedge clk);
      rd_chk(CTRL_STATUS_ADDR, 8'h11);
      i_master.xfer(mode_zero_code, 8'h4B, 1'b0, got);
      `CHK(got, 8'h69)
      rd_chk(RX_DATA_ADDR, 8'h4B);
      wr(SELECT_ADDR, 8'h00);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(CTRL_STATUS_ADDR, transmit_empty_flag);
      `CHK(irq, 1'b0)
      modes_and_orders();
      overrun_case();
      irq_case();
      disable_case();
      soft_select_case();
      report_and_stop();
   end
   // Watchdog: all frames need far less than a millisecond
   initial begin
      #1_000_000;
      miscompares++;
      report_and_stop();
   end
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
endmodule
`default_nettype wire
